// ---- core/rst_supply_cfg.svh ----
// Register map, field positions, reset values and timing counts
`ifndef RST_SUPPLY_CFG_SVH
`define RST_SUPPLY_CFG_SVH

// Register indices; byte address on the bus is four times the index
`define IDX_SUPPLY_DETECT_CTRL 16'hff50
`define IDX_THRESHOLD_SELECT 16'hff51
`define IDX_RESET_CAUSE 16'hff54
`define IDX_IRQ_STATUS 16'hff58
`define IDX_IRQ_MASK 16'hff59

// Supply detect control fields
`define BIT_DETECTOR_ENABLE 7
`define BIT_DETECT_RESPONSE_SEL 1
`define BIT_LOW_SUPPLY_FLAG 0

// Reset cause fields
`define BIT_WATCHDOG_CAUSE 4
`define BIT_UNDERVOLT_CAUSE 0

// Threshold select field
`define THRESHOLD_W 4
`define THRESHOLD_MAX_CODE 4'h9

// Interrupt status and mask fields
`define IRQ_W 3
`define BIT_IRQ_LOW_SUPPLY 0
`define BIT_IRQ_WATCHDOG 1
`define BIT_IRQ_UNDERVOLT 2

// Reset values
`define RST_SUPPLY_DETECT_CTRL 8'h00
`define RST_THRESHOLD_SELECT 4'h0
`define RST_RESET_CAUSE 8'h00
`define RST_IRQ_MASK 3'h0

// Internal reset stretch after a watchdog request, in clock cycles
`define WDT_HOLD_CYCLES 16

`endif

// ---- core/rst_supply_pkg.sv ----
// Types shared by the reset cause and supply detector logic
package rst_supply_pkg;

    // What the reset source arbitration decided in this cycle
    typedef enum logic [1:0] {
        cause_none = 2'b00,
        cause_pin_or_poc = 2'b01,
        cause_watchdog = 2'b10,
        cause_undervolt = 2'b11
    } reset_cause_type;

endpackage

// ---- core/sync_two_flop.sv ----
// Two flip-flop synchroniser, one chain per bit
`timescale 1ns/1ps

module sync_two_flop #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            logic first_stage;
            // First stage feeds only the second stage
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    first_stage <= RESET_VALUE[b];
                    sync_o[b] <= RESET_VALUE[b];
                end else begin
                    first_stage <= async_i[b];
                    sync_o[b] <= first_stage;
                end
            end
        end
    endgenerate

endmodule

// ---- core/sticky_irq_bank.sv ----
// Sticky event status with write-one-to-clear, mask and level interrupt
`timescale 1ns/1ps

module sticky_irq_bank #(
    parameter int WIDTH = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic [WIDTH-1:0] event_i,
    input wire logic clear_we_i,
    input wire logic [WIDTH-1:0] clear_dat_i,
    input wire logic mask_we_i,
    input wire logic [WIDTH-1:0] mask_dat_i,
    output logic [WIDTH-1:0] status_o,
    output logic [WIDTH-1:0] mask_o,
    output logic irq_o
);

    genvar b;
    generate
        for (b = 0; b < WIDTH; b = b + 1) begin : g_bit
            // Event wins over a clear in the same cycle
            always_ff @(posedge clk_i) begin
                if (rst_i || flush_i) begin
                    status_o[b] <= 1'b0;
                end else if (event_i[b]) begin
                    status_o[b] <= 1'b1;
                end else if (clear_we_i && clear_dat_i[b]) begin
                    status_o[b] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask: a one lets the status bit reach the interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_o <= '0;
        end else if (mask_we_i) begin
            mask_o <= mask_dat_i;
        end
    end

    assign irq_o = |(status_o & mask_o);

endmodule

// ---- core/reset_cause_and_low_voltage_ctrl.sv ----
// Reset cause record, power-on-clear reset and supply detector control
`timescale 1ns/1ps
`include "rst_supply_cfg.svh"

// Contract
// - A read of the reset cause register returns it, then clears it.
// - Watchdog reset sets bit 4; undervolt reset leaves it unchanged.
// - Undervolt reset sets bit 0; watchdog reset leaves it unchanged.
// - Pin or power-on-clear reset clears both cause flags.
// - Internal reset at power-on and while power-on-clear reports low.
// - Control bit 7 starts the supply comparator; zero disables it.
// - Control bit 1 picks interrupt (0) or internal reset (1).
// - Control bit 0 is read-only, one while enabled supply is low.
// - Low-supply request follows the flag only when enabled, interrupt mode.
// - Control register clears on every reset except undervolt reset.
// - Control register accepts single-bit and whole-byte writes; the bus port here takes whole-byte writes on lane 0 only.
// - Ten software-selectable thresholds; detection runs in stop mode.
// - Threshold code in bits 3..0, codes 0..9 valid, upper bits zero.
// - Reset mode holds internal reset while supply stays below threshold.
module reset_cause_and_low_voltage_ctrl
    import rst_supply_pkg::*;
#(
    parameter int ADR_W = 18,
    parameter int WDT_HOLD = `WDT_HOLD_CYCLES
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic ext_reset_n_i,
    input wire logic poc_below_i,
    input wire logic lvi_below_i,
    input wire logic wdt_reset_req_i,
    output logic detector_enable_o,
    output logic [`THRESHOLD_W-1:0] threshold_select_o,
    output logic internal_reset_o,
    output logic low_supply_irq_o,
    output logic irq_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    ////////////////////////////////////////////////////////////////////////

    logic [2:0] pins_sync;
    logic ext_reset_low;
    logic poc_low;
    logic supply_low;

    logic detector_enable;
    logic detect_response_sel;
    logic [`THRESHOLD_W-1:0] threshold_select;
    logic watchdog_cause_flag;
    logic undervolt_cause_flag;

    logic low_supply_flag;
    logic undervolt_reset_req;
    logic low_supply_irq_d;

    logic [15:0] wdt_hold_count;
    logic wdt_hold_active;
    reset_cause_type next_cause;

    logic bus_req;
    logic bus_wr;
    logic bus_rd;
    logic [15:0] reg_index;
    logic hit_ctrl;
    logic hit_thresh;
    logic hit_cause;
    logic hit_status;
    logic hit_mask;
    logic [7:0] next_dat;

    logic [`IRQ_W-1:0] irq_events;
    logic [`IRQ_W-1:0] irq_status;
    logic [`IRQ_W-1:0] irq_mask;
    logic flush_status;

    localparam logic [15:0] WDT_LOAD = 16'(WDT_HOLD - 1);

    // Reset images as vectors, since a bare literal cannot be bit-selected
    localparam logic [7:0] CTRL_RESET = `RST_SUPPLY_DETECT_CTRL;
    localparam logic [7:0] CAUSE_RESET = `RST_RESET_CAUSE;

    ////////////////////////////////////////////////////////////////////////
    // Pin and comparator synchronisers
    ////////////////////////////////////////////////////////////////////////

    // Reset value says "power-on-clear low, pin asserted" so power-up holds reset
    sync_two_flop #(
        .WIDTH(3),
        .RESET_VALUE(3'b110)
    ) u_pin_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({~ext_reset_n_i, poc_below_i, lvi_below_i}),
        .sync_o(pins_sync)
    );

    assign ext_reset_low = pins_sync[2];
    assign poc_low = pins_sync[1];
    assign supply_low = pins_sync[0];

    ////////////////////////////////////////////////////////////////////////
    // Supply detector status and requests
    ////////////////////////////////////////////////////////////////////////

    // Flag only means anything while the comparator runs
    assign low_supply_flag = detector_enable & supply_low;

    // Reset mode: level request, released as soon as supply recovers
    assign undervolt_reset_req = low_supply_flag & detect_response_sel;

    // Interrupt mode: the request mirrors the flag
    assign low_supply_irq_d = low_supply_flag & ~detect_response_sel;

    // Request as a registered level toward the interrupt controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            low_supply_irq_o <= 1'b0;
        end else begin
            low_supply_irq_o <= low_supply_irq_d;
        end
    end

    // Analog side: comparator enable and level code
    assign detector_enable_o = detector_enable;
    assign threshold_select_o = threshold_select;

    ////////////////////////////////////////////////////////////////////////
    // Watchdog reset stretch
    ////////////////////////////////////////////////////////////////////////

    // A watchdog request is one pulse; stretch it so the core sees it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wdt_hold_count <= 16'h0000;
        end else if (wdt_reset_req_i) begin
            wdt_hold_count <= WDT_LOAD;
        end else if (wdt_hold_count != 16'h0000) begin
            wdt_hold_count <= wdt_hold_count - 16'h0001;
        end
    end

    assign wdt_hold_active = wdt_reset_req_i | (wdt_hold_count != 16'h0000);

    ////////////////////////////////////////////////////////////////////////
    // Reset source arbitration
    ////////////////////////////////////////////////////////////////////////

    // Pin and power-on-clear outrank the internal sources: they wipe all but the mask
    always_comb begin
        if (ext_reset_low || poc_low) begin
            next_cause = cause_pin_or_poc;
        end else if (wdt_reset_req_i) begin
            next_cause = cause_watchdog;
        end else if (undervolt_reset_req) begin
            next_cause = cause_undervolt;
        end else begin
            next_cause = cause_none;
        end
    end

    // Internal reset; held high through the system reset itself
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            internal_reset_o <= 1'b1;
        end else begin
            internal_reset_o <= ext_reset_low | poc_low | wdt_hold_active
                | undervolt_reset_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wishbone decode
    ////////////////////////////////////////////////////////////////////////

    assign bus_req = cyc_i & stb_i & ~ack_o;
    assign bus_wr = bus_req & we_i & sel_i[0];
    assign bus_rd = bus_req & ~we_i;
    assign reg_index = adr_i[17:2];

    // Address decode by register index
    always_comb begin
        hit_ctrl = 1'b0;
        hit_thresh = 1'b0;
        hit_cause = 1'b0;
        hit_status = 1'b0;
        hit_mask = 1'b0;
        if (reg_index == `IDX_SUPPLY_DETECT_CTRL) begin
            hit_ctrl = 1'b1;
        end else if (reg_index == `IDX_THRESHOLD_SELECT) begin
            hit_thresh = 1'b1;
        end else if (reg_index == `IDX_RESET_CAUSE) begin
            hit_cause = 1'b1;
        end else if (reg_index == `IDX_IRQ_STATUS) begin
            hit_status = 1'b1;
        end else if (reg_index == `IDX_IRQ_MASK) begin
            hit_mask = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Supply detect control register
    ////////////////////////////////////////////////////////////////////////

    // Undervolt reset leaves the register alone so the mode survives
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            detector_enable <= CTRL_RESET[`BIT_DETECTOR_ENABLE];
            detect_response_sel <= CTRL_RESET[`BIT_DETECT_RESPONSE_SEL];
        end else if (next_cause == cause_pin_or_poc
                     || next_cause == cause_watchdog) begin
            detector_enable <= 1'b0;
            detect_response_sel <= 1'b0;
        end else if (bus_wr && hit_ctrl) begin
            // Whole byte; bit 0 is read-only, bits 6..2 are don't-care
            detector_enable <= dat_i[`BIT_DETECTOR_ENABLE];
            detect_response_sel <= dat_i[`BIT_DETECT_RESPONSE_SEL];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Threshold select register
    ////////////////////////////////////////////////////////////////////////

    // Prohibited codes are dropped so the comparator never sees them
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            threshold_select <= `RST_THRESHOLD_SELECT;
        end else if (next_cause == cause_pin_or_poc
                     || next_cause == cause_watchdog) begin
            threshold_select <= `RST_THRESHOLD_SELECT;
        end else if (bus_wr && hit_thresh
                     && dat_i[3:0] <= `THRESHOLD_MAX_CODE) begin
            threshold_select <= dat_i[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset cause register
    ////////////////////////////////////////////////////////////////////////

    // Watchdog flag: set by watchdog, held by undervolt, cleared by pin
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            watchdog_cause_flag <= CAUSE_RESET[`BIT_WATCHDOG_CAUSE];
        end else if (next_cause == cause_pin_or_poc) begin
            watchdog_cause_flag <= 1'b0;
        end else if (next_cause == cause_watchdog) begin
            watchdog_cause_flag <= 1'b1;
        end else if (bus_rd && hit_cause) begin
            watchdog_cause_flag <= 1'b0;
        end
    end

    // Undervolt flag: a reset in progress wins over a read clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            undervolt_cause_flag <= CAUSE_RESET[`BIT_UNDERVOLT_CAUSE];
        end else if (next_cause == cause_pin_or_poc) begin
            undervolt_cause_flag <= 1'b0;
        end else if (undervolt_reset_req) begin
            undervolt_cause_flag <= 1'b1;
        end else if (bus_rd && hit_cause) begin
            undervolt_cause_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status
    ////////////////////////////////////////////////////////////////////////

    // Events: low-supply request rising, watchdog and undervolt resets
    always_comb begin
        irq_events = '0;
        irq_events[`BIT_IRQ_LOW_SUPPLY] = low_supply_irq_d & ~low_supply_irq_o;
        irq_events[`BIT_IRQ_WATCHDOG] = next_cause == cause_watchdog;
        irq_events[`BIT_IRQ_UNDERVOLT] = undervolt_reset_req
            & ~undervolt_cause_flag;
    end

    assign flush_status = next_cause == cause_pin_or_poc;

    sticky_irq_bank #(
        .WIDTH(`IRQ_W)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .flush_i(flush_status),
        .event_i(irq_events),
        .clear_we_i(bus_wr && hit_status),
        .clear_dat_i(dat_i[`IRQ_W-1:0]),
        .mask_we_i(bus_wr && hit_mask),
        .mask_dat_i(dat_i[`IRQ_W-1:0]),
        .status_o(irq_status),
        .mask_o(irq_mask),
        .irq_o(irq_o)
    );

    ////////////////////////////////////////////////////////////////////////
    // Read data and acknowledge
    ////////////////////////////////////////////////////////////////////////

    // Read mux; unused bits and unmapped indices read zero
    always_comb begin
        next_dat = 8'h00;
        if (hit_ctrl) begin
            next_dat[`BIT_DETECTOR_ENABLE] = detector_enable;
            next_dat[`BIT_DETECT_RESPONSE_SEL] = detect_response_sel;
            next_dat[`BIT_LOW_SUPPLY_FLAG] = low_supply_flag;
        end else if (hit_thresh) begin
            next_dat[3:0] = threshold_select;
        end else if (hit_cause) begin
            next_dat[`BIT_WATCHDOG_CAUSE] = watchdog_cause_flag;
            next_dat[`BIT_UNDERVOLT_CAUSE] = undervolt_cause_flag;
        end else if (hit_status) begin
            next_dat[`IRQ_W-1:0] = irq_status;
        end else if (hit_mask) begin
            next_dat[`IRQ_W-1:0] = irq_mask;
        end
    end

    // One wait state: ack and data land together, ack lasts one cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= bus_req;
        end
    end

    // Data captured at the same edge that clears the cause register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (bus_rd) begin
            dat_o <= {24'h00_0000, next_dat};
        end
    end

endmodule

// ---- testbench/reset_cause_and_low_voltage_ctrl_assertions.sv ----
// Port-level checker for the reset cause and supply detector block
`timescale 1ns/1ps
`include "rst_supply_cfg.svh"

module reset_cause_and_low_voltage_ctrl_assertions #(
    parameter int ADR_W = 18,
    parameter int WDT_HOLD = 16
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic ext_reset_n_i,
    input wire logic poc_below_i,
    input wire logic lvi_below_i,
    input wire logic wdt_reset_req_i,
    input wire logic detector_enable_o,
    input wire logic [`THRESHOLD_W-1:0] threshold_select_o,
    input wire logic internal_reset_o,
    input wire logic low_supply_irq_o,
    input wire logic irq_o
);
    logic [7:0] quiet_cnt;

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Cycles with every reset source idle; saturates
    always_ff @(posedge clk_i) begin
        if (rst_i || !ext_reset_n_i || poc_below_i || lvi_below_i ||
            wdt_reset_req_i) begin
            quiet_cnt <= 8'h00;
        end else if (quiet_cnt != 8'hff) begin
            quiet_cnt <= quiet_cnt + 8'h01;
        end
    end

    sequence bus_taken;
        cyc_i && stb_i && !ack_o;
    endsequence

    // Comparator quiet long enough that the sync chain holds zeros
    sequence lvi_quiet_then_rise;
        !lvi_below_i [*3] ##1 lvi_below_i;
    endsequence

    AST_ACK_NEXT: assert property (bus_taken |=> ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_DAT_UPPER_ZERO: assert property (
        ack_o |-> dat_o[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    AST_SYNC_DELAY: assert property (
        lvi_quiet_then_rise |=> !low_supply_irq_o [*2])
        else $error("low supply request bypassed the synchroniser");
    AST_IRQ_NEEDS_ENABLE: assert property (
        !detector_enable_o [*2] |-> !low_supply_irq_o)
        else $error("low supply request while detector disabled");
    AST_POC_HOLDS_RESET: assert property (
        poc_below_i [*4] |-> internal_reset_o)
        else $error("internal reset low while supply below clear level");
    AST_RESET_RELEASE: assert property (
        (quiet_cnt >= 8'(WDT_HOLD + 4)) |-> !internal_reset_o)
        else $error("internal reset held with all sources idle");
    AST_WDT_RESET: assert property (
        wdt_reset_req_i |-> ##[1:2] internal_reset_o)
        else $error("watchdog request gave no internal reset");
    AST_WDT_CLEARS_CTRL: assert property (
        wdt_reset_req_i |-> ##2
        (!detector_enable_o && threshold_select_o == 4'h0))
        else $error("control not cleared by watchdog reset");
    AST_PIN_CLEARS_CTRL: assert property (
        !ext_reset_n_i [*4] |->
        (!detector_enable_o && threshold_select_o == 4'h0))
        else $error("control not cleared by pin reset");
endmodule

bind reset_cause_and_low_voltage_ctrl
    reset_cause_and_low_voltage_ctrl_assertions #(
    .ADR_W(ADR_W), .WDT_HOLD(WDT_HOLD)) chk_i (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .ext_reset_n_i(ext_reset_n_i), .poc_below_i(poc_below_i),
    .lvi_below_i(lvi_below_i), .wdt_reset_req_i(wdt_reset_req_i),
    .detector_enable_o(detector_enable_o),
    .threshold_select_o(threshold_select_o),
    .internal_reset_o(internal_reset_o), .low_supply_irq_o(low_supply_irq_o),
    .irq_o(irq_o));

// ---- testbench/tb_top.sv ----
// Self-checking bench for the reset cause and supply detector block
`timescale 1ns/1ps
`include "rst_supply_cfg.svh"

module tb_top;
    localparam int HOLD = 2;
    localparam int SETTLE_CYCLES = 5000; // 0.2 ms of 40 ns cycles
    localparam logic [15:0] ctrl = `IDX_SUPPLY_DETECT_CTRL;
    localparam logic [15:0] thr = `IDX_THRESHOLD_SELECT;
    localparam logic [15:0] cause = `IDX_RESET_CAUSE;
    localparam logic [15:0] stat = `IDX_IRQ_STATUS;
    localparam logic [15:0] mask = `IDX_IRQ_MASK;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [17:0] adr_i = 18'h00000;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h00000000;
    logic ext_reset_n_i = 1'b1, poc_below_i = 1'b0;
    logic lvi_below_i = 1'b0, wdt_reset_req_i = 1'b0;
    logic [31:0] dat_o, rd;
    logic ack_o, detector_enable_o, internal_reset_o, low_supply_irq_o;
    logic irq_o, seen;
    logic [3:0] threshold_select_o;
    int mismatches = 0;
    int check_count = 0;

    always #20 clk_i = ~clk_i;

    reset_cause_and_low_voltage_ctrl #(.ADR_W(18), .WDT_HOLD(HOLD))
        reset_cause_and_low_voltage_ctrl_i (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .ext_reset_n_i(ext_reset_n_i),
        .poc_below_i(poc_below_i), .lvi_below_i(lvi_below_i),
        .wdt_reset_req_i(wdt_reset_req_i),
        .detector_enable_o(detector_enable_o),
        .threshold_select_o(threshold_select_o),
        .internal_reset_o(internal_reset_o),
        .low_supply_irq_o(low_supply_irq_o), .irq_o(irq_o));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] got,
        input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One classic cycle; ack and read data are taken at the rising edge
    task automatic wb(input logic w, input logic [15:0] idx,
        input logic [7:0] d, input logic [3:0] s = 4'h1);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= {idx, 2'b00};
        sel_i <= s;
        dat_i <= {24'h000000, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 20);
        check("bus ack", 32'(ack_o), 32'h1);
        rd = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [15:0] idx,
        input logic [7:0] exp);
        wb(1'b0, idx, 8'h00);
        check(name, rd, {24'h000000, exp});
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    // Bounded wait for the internal reset to drop
    task automatic wait_release();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (internal_reset_o !== 1'b0 && n < 50);
        check("reset release", 32'(internal_reset_o), 32'h0);
    endtask

    task automatic pulse_wdt();
        @(posedge clk_i) wdt_reset_req_i <= 1'b1;
        @(posedge clk_i) wdt_reset_req_i <= 1'b0;
        seen = 1'b0;
        repeat (HOLD + 2) begin
            @(negedge clk_i);
            seen = seen | internal_reset_o;
        end
        check("wdt reset", 32'(seen), 32'h1);
        wait_release();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog on the whole run; real run is just over five thousand cycles
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        test_done();
    end

    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_release();
        rdchk("ctrl", ctrl, 8'h00);
        rdchk("threshold", thr, 8'h00);
        rdchk("cause", cause, 8'h00);
        rdchk("unmapped", 16'hff5f, 8'h00);
        $display("test reset values done");
        // Lane off is ignored, bit 0 write is ignored
        wb(1'b1, ctrl, 8'h82, 4'h0);
        rdchk("ctrl lane", ctrl, 8'h00);
        wb(1'b1, ctrl, 8'h83);
        rdchk("ctrl byte", ctrl, 8'h82);
        check("enable pin", 32'(detector_enable_o), 32'h1);
        for (int c = 0; c < 10; c++) begin
            wb(1'b1, thr, 8'(c));
            @(negedge clk_i);
            check("threshold pin", 32'(threshold_select_o), 32'(c));
        end
        wb(1'b1, thr, 8'h0a);
        rdchk("threshold kept", thr, 8'h09);
        $display("test register writes done");
        // Interrupt mode: flag, request, sticky status, mask
        wb(1'b1, ctrl, 8'h80);
        settle(SETTLE_CYCLES);
        @(posedge clk_i) lvi_below_i <= 1'b1;
        settle(4);
        check("request", 32'(low_supply_irq_o), 32'h1);
        check("irq masked", 32'(irq_o), 32'h0);
        rdchk("flag", ctrl, 8'h81);
        wb(1'b1, mask, 8'h01);
        @(negedge clk_i);
        check("irq", 32'(irq_o), 32'h1);
        wb(1'b1, stat, 8'h01);
        @(negedge clk_i);
        check("irq cleared", 32'(irq_o), 32'h0);
        wb(1'b1, ctrl, 8'h00);
        settle(2);
        check("request off", 32'(low_supply_irq_o), 32'h0);
        rdchk("flag off", ctrl, 8'h00);
        @(posedge clk_i) lvi_below_i <= 1'b0;
        $display("test interrupt mode done");
        // Reset mode: held while low, control survives
        wb(1'b1, thr, 8'h05);
        wb(1'b1, ctrl, 8'h82);
        @(posedge clk_i) lvi_below_i <= 1'b1;
        settle(4);
        check("lvi reset", 32'(internal_reset_o), 32'h1);
        check("no request", 32'(low_supply_irq_o), 32'h0);
        @(posedge clk_i) lvi_below_i <= 1'b0;
        wait_release();
        rdchk("ctrl kept", ctrl, 8'h82);
        rdchk("threshold kept", thr, 8'h05);
        pulse_wdt();
        rdchk("ctrl wdt", ctrl, 8'h00);
        rdchk("status", stat, 8'h06);
        rdchk("cause both", cause, 8'h11);
        rdchk("cause read clear", cause, 8'h00);
        pulse_wdt();
        rdchk("cause wdt", cause, 8'h10);
        $display("test reset causes done");
        // Pin then power-on-clear wipe the flags and control
        for (int s = 0; s < 2; s++) begin
            pulse_wdt();
            wb(1'b1, ctrl, 8'h80);
            @(posedge clk_i);
            if (s == 0) begin
                ext_reset_n_i <= 1'b0;
            end else begin
                poc_below_i <= 1'b1;
            end
            settle(4);
            check("src reset", 32'(internal_reset_o), 32'h1);
            @(posedge clk_i);
            ext_reset_n_i <= 1'b1;
            poc_below_i <= 1'b0;
            wait_release();
            rdchk("cause src", cause, 8'h00);
            rdchk("ctrl src", ctrl, 8'h00);
        end
        $display("test pin and power-on reset done");
        test_done();
    end
endmodule
